// [rtl/cmb_cfg.svh]
// Offsets, field positions, reset values and counts of the CAN message buffer block
`ifndef CMB_CFG_SVH
`define CMB_CFG_SVH
// Offsets inside one 16-byte buffer window
`define CMB_OFS_ID_HIGH     4'h0
`define CMB_OFS_ID_LOW      4'h1
`define CMB_OFS_DATA_FIRST  4'h4
`define CMB_OFS_DATA_LAST   4'hb
`define CMB_OFS_LENGTH      4'hc
`define CMB_OFS_PRIORITY    4'hd
`define CMB_OFS_STAMP_HIGH  4'he
`define CMB_OFS_STAMP_LOW   4'hf
// Window bases (upper address nibble) and control block
`define CMB_RX_WINDOW       4'h2
`define CMB_TX_WINDOW       4'h3
`define CMB_ADDR_CTRL       8'h40
`define CMB_ADDR_TX_FLAGS   8'h41
`define CMB_ADDR_TX_SELECT  8'h42
`define CMB_ADDR_IRQ_STATUS 8'h43
`define CMB_ADDR_IRQ_MASK   8'h44
// Field positions
`define CMB_ID_LOW_MSB      7
`define CMB_ID_LOW_LSB      5
`define CMB_RTR_BIT         4
`define CMB_IDE_BIT         3
`define CMB_CTRL_INIT_BIT   0
`define CMB_CTRL_STAMP_BIT  1
// Widths, counts and reset values
`define CMB_STD_ID_BITS     11
`define CMB_MAX_BYTES       4'h8
`define CMB_PRIORITY_FIELD_RESET      8'h00
`define CMB_CTRL_RESET      8'h01
`endif

// [rtl/cmb_pkg.sv]
// Types shared by the CAN message buffer block
package cmb_pkg;
  typedef enum logic {ser_idle, ser_shift} cmb_ser_e;
  typedef logic [7:0] cmb_byte_t;
endpackage : cmb_pkg

// [rtl/cmb_msg_buffers.sv]
// CAN message buffers: transmit buffers with local arbitration, receive buffer, stamp timer
//
// Behaviour
// - Standard identifier is 11 bits, shifted out most significant bit first.
// - Smallest identifier value is the highest priority identifier.
// - Identifier low byte: bits 7-5 id[2:0], bit 4 remote, bit 3 extended.
// - Remote bit reads as received; in transmit buffers it selects the sent frame.
// - Extended flag reads as received; in transmit buffers 0 standard, 1 extended.
// - Eight data bytes per buffer; only length-code bytes sent or taken.
// - Length code in bits 3-0; codes 0 to 8 give 0 to 8 bytes.
// - Remote frame sends length code as programmed but no data bytes.
// - Each transmit buffer has 8-bit local priority, reset zero, smaller wins.
// - Before start of frame, pick pending buffer with lowest local priority.
// - Equal lowest priority goes to the lower buffer index.
// - Priority accessible only when selected buffer's empty flag is set.
// - With stamping on, timer value stored into active buffer after valid frame.
// - Stamp timer is free-running 16-bit, counts bit clock, no overrun flag.
// - Stamp timer held at zero while in initialization mode.
// - Stamp bytes read-only; transmit stamp readable only once buffer is empty.
// - Host clears empty flag to send; device sets it after successful send.
// - Host selects an empty transmit buffer to map it into the transmit window.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "cmb_cfg.svh"

module cmb_msg_buffers #(
  parameter int NUM_TX = 3,
  parameter int IW     = 2
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  output logic               irq,
  input  wire logic          bit_tick,
  input  wire logic          sof_request,
  input  wire logic          tx_done,
  output logic               tx_sel_valid,
  output logic [IW-1:0]      tx_sel_index,
  output logic               tx_ide,
  output logic               tx_rtr,
  output logic [3:0]         tx_dlc,
  output logic [3:0]         tx_byte_count,
  output logic               tx_id_bit,
  output logic               tx_id_shifting,
  input  wire logic [2:0]    tx_byte_idx,
  output logic [7:0]         tx_byte_data,
  input  wire logic          rx_valid,
  input  wire logic [10:0]   rx_id,
  input  wire logic          rx_rtr,
  input  wire logic          rx_ide,
  input  wire logic [3:0]    rx_dlc,
  input  wire logic [63:0]   rx_data,
  output logic               init_mode
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  cmb_pkg::cmb_byte_t tx_idh_q  [NUM_TX];
  cmb_pkg::cmb_byte_t tx_idl_q  [NUM_TX];
  cmb_pkg::cmb_byte_t tx_len_q  [NUM_TX];
  cmb_pkg::cmb_byte_t tx_priority_field_q [NUM_TX];
  cmb_pkg::cmb_byte_t tx_data_q [NUM_TX][8];
  logic [15:0]        tx_stamp_q[NUM_TX];
  cmb_pkg::cmb_byte_t rx_idh_q, rx_idl_q, rx_len_q;
  cmb_pkg::cmb_byte_t rx_data_q [8];
  logic [15:0]        rx_stamp_q;
  logic [7:0]         ctrl_q, irq_mask_q, irq_stat_q, rdata_q;
  logic [NUM_TX-1:0]  empty_q, sel_q;
  logic [15:0]        timer_q;
  logic [IW-1:0]      act_q;
  logic               act_valid_q;
  logic [10:0]        shift_q;
  logic [3:0]         shift_cnt_q;
  cmb_pkg::cmb_ser_e  ser_q;
  logic               ide_q, rtr_q;
  logic [3:0]         dlc_q, cnt_q;
  logic [7:0]         byte_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [3:0]         ofs;
  logic               rx_win, tx_win, is_data;
  logic [2:0]         dix;
  logic [IW-1:0]      sel_idx;
  logic               sel_any, sel_empty;

  assign ofs     = reg_addr[3:0];
  assign rx_win  = reg_addr[7:4] == `CMB_RX_WINDOW;
  assign tx_win  = reg_addr[7:4] == `CMB_TX_WINDOW;
  assign is_data = ofs >= `CMB_OFS_DATA_FIRST && ofs <= `CMB_OFS_DATA_LAST;
  assign dix     = 3'(ofs - `CMB_OFS_DATA_FIRST);
  assign init_mode = ctrl_q[`CMB_CTRL_INIT_BIT];

  // Index of the selected transmit buffer from the one-hot pointer
  always_comb begin
    sel_idx = '0;
    sel_any = 1'b0;
    for (int i = NUM_TX - 1; i >= 0; i--) begin
      if (sel_q[i]) begin
        sel_idx = IW'(i);
        sel_any = 1'b1;
      end
    end
  end
  assign sel_empty = sel_any && empty_q[sel_idx];

  // Payload byte count from a length code and remote flag
  function automatic logic [3:0] byte_count(input logic [3:0] dlc, input logic rtr);
    if (rtr)
      return 4'h0;
    return (dlc > `CMB_MAX_BYTES) ? `CMB_MAX_BYTES : dlc;
  endfunction : byte_count

  // ----------------------------------------------------------------
  // Local arbitration
  // ----------------------------------------------------------------
  // Strict less-than keeps the first, lower-index buffer on a tie
  logic [IW-1:0] win_idx;
  logic          win_any;
  logic [7:0]    win_priority_field;
  always_comb begin
    win_idx  = '0;
    win_any  = 1'b0;
    win_priority_field = 8'hff;
    for (int i = 0; i < NUM_TX; i++) begin
      if (!empty_q[i] && (!win_any || tx_priority_field_q[i] < win_priority_field)) begin
        win_idx  = IW'(i);
        win_any  = 1'b1;
        win_priority_field = tx_priority_field_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Init mode comes up set so the timer starts from zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q     <= `CMB_CTRL_RESET;
      irq_mask_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `CMB_ADDR_CTRL)
        ctrl_q <= reg_wdata;
      if (reg_addr == `CMB_ADDR_IRQ_MASK)
        irq_mask_q <= reg_wdata;
    end
  end

  // Selection takes the lowest requested buffer that is empty
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= '0;
    end else if (reg_wr && reg_addr == `CMB_ADDR_TX_SELECT) begin
      sel_q <= '0;
      for (int i = NUM_TX - 1; i >= 0; i--) begin
        if (reg_wdata[i] && empty_q[i])
          sel_q <= NUM_TX'(1) << i;
      end
    end
  end

  // Empty flags: host write-one clears, the device set comes last and wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      empty_q <= '1;
    end else begin
      if (reg_wr && reg_addr == `CMB_ADDR_TX_FLAGS)
        empty_q <= empty_q & ~reg_wdata[NUM_TX-1:0];
      if (tx_done && act_valid_q)
        empty_q[act_q] <= 1'b1;
    end
  end

  // Sticky events: buffer emptied per bit, bit NUM_TX for reception; a read clears
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_q <= 8'h00;
    end else begin
      if (reg_rd && reg_addr == `CMB_ADDR_IRQ_STATUS)
        irq_stat_q <= 8'h00;
      if (tx_done && act_valid_q)
        irq_stat_q[act_q] <= 1'b1;
      if (rx_valid)
        irq_stat_q[NUM_TX] <= 1'b1;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Stamp timer
  // ----------------------------------------------------------------
  // Wraps silently; software must handle overrun itself
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      timer_q <= 16'h0000;
    else if (init_mode)
      timer_q <= 16'h0000;
    else if (bit_tick)
      timer_q <= timer_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Transmit buffer contents
  // ----------------------------------------------------------------
  // Host writes reach only the selected buffer; stamps are never written by the host
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_TX; i++) begin
        tx_idh_q[i]   <= 8'h00;
        tx_idl_q[i]   <= 8'h00;
        tx_len_q[i]   <= 8'h00;
        tx_priority_field_q[i]  <= `CMB_PRIORITY_FIELD_RESET;
        tx_stamp_q[i] <= 16'h0000;
        for (int j = 0; j < 8; j++)
          tx_data_q[i][j] <= 8'h00;
      end
    end else begin
      if (reg_wr && tx_win && sel_any) begin
        if (ofs == `CMB_OFS_ID_HIGH)
          tx_idh_q[sel_idx] <= reg_wdata;
        if (ofs == `CMB_OFS_ID_LOW)
          tx_idl_q[sel_idx] <= reg_wdata;
        if (ofs == `CMB_OFS_LENGTH)
          tx_len_q[sel_idx] <= reg_wdata;
        if (ofs == `CMB_OFS_PRIORITY && sel_empty)
          tx_priority_field_q[sel_idx] <= reg_wdata;
        if (is_data)
          tx_data_q[sel_idx][dix] <= reg_wdata;
      end
      if (tx_done && act_valid_q && ctrl_q[`CMB_CTRL_STAMP_BIT])
        tx_stamp_q[act_q] <= timer_q;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // Bytes beyond the byte count keep their old value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_idh_q   <= 8'h00;
      rx_idl_q   <= 8'h00;
      rx_len_q   <= 8'h00;
      rx_stamp_q <= 16'h0000;
      for (int j = 0; j < 8; j++)
        rx_data_q[j] <= 8'h00;
    end else if (rx_valid) begin
      rx_idh_q <= rx_id[10:3];
      rx_idl_q <= {rx_id[2:0], rx_rtr, rx_ide, 3'h0};
      rx_len_q <= {4'h0, rx_dlc};
      for (int j = 0; j < 8; j++) begin
        if (4'(j) < byte_count(rx_dlc, rx_rtr))
          rx_data_q[j] <= rx_data[8*j +: 8];
      end
      if (ctrl_q[`CMB_CTRL_STAMP_BIT])
        rx_stamp_q <= timer_q;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration latch and frame fields
  // ----------------------------------------------------------------
  // The winner is frozen at start of frame so host edits cannot move it mid-frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      act_q       <= '0;
      act_valid_q <= 1'b0;
      ide_q       <= 1'b0;
      rtr_q       <= 1'b0;
      dlc_q       <= 4'h0;
      cnt_q       <= 4'h0;
    end else if (sof_request) begin
      act_q       <= win_idx;
      act_valid_q <= win_any;
      ide_q       <= tx_idl_q[win_idx][`CMB_IDE_BIT];
      rtr_q       <= tx_idl_q[win_idx][`CMB_RTR_BIT];
      dlc_q       <= tx_len_q[win_idx][3:0];
      cnt_q       <= byte_count(tx_len_q[win_idx][3:0], tx_idl_q[win_idx][`CMB_RTR_BIT]);
    end else if (tx_done) begin
      act_valid_q <= 1'b0;
    end
  end

  // Identifier serializer, one bit per bit tick, most significant first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_q       <= cmb_pkg::ser_idle;
      shift_q     <= 11'h000;
      shift_cnt_q <= 4'h0;
    end else begin
      unique case (ser_q)
        cmb_pkg::ser_idle: begin
          if (sof_request && win_any) begin
            shift_q     <= {tx_idh_q[win_idx], tx_idl_q[win_idx][`CMB_ID_LOW_MSB:`CMB_ID_LOW_LSB]};
            shift_cnt_q <= 4'(`CMB_STD_ID_BITS);
            ser_q       <= cmb_pkg::ser_shift;
          end
        end
        cmb_pkg::ser_shift: begin
          if (bit_tick) begin
            shift_q     <= {shift_q[9:0], 1'b0};
            shift_cnt_q <= shift_cnt_q - 4'h1;
            if (shift_cnt_q == 4'h1)
              ser_q <= cmb_pkg::ser_idle;
          end
        end
      endcase
    end
  end

  // Payload byte for the protocol engine, one cycle after its index
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      byte_q <= 8'h00;
    else
      byte_q <= tx_data_q[act_q][tx_byte_idx];
  end

  assign tx_sel_valid   = act_valid_q;
  assign tx_sel_index   = act_q;
  assign tx_ide         = ide_q;
  assign tx_rtr         = rtr_q;
  assign tx_dlc         = dlc_q;
  assign tx_byte_count  = cnt_q;
  assign tx_id_bit      = shift_q[10];
  assign tx_id_shifting = ser_q == cmb_pkg::ser_shift;
  assign tx_byte_data   = byte_q;

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Guarded reads return zero rather than another buffer's state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (!reg_rd) begin
      rdata_q <= 8'h00;
    end else if (rx_win) begin
      rdata_q <= 8'h00;
      if (ofs == `CMB_OFS_ID_HIGH)    rdata_q <= rx_idh_q;
      if (ofs == `CMB_OFS_ID_LOW)     rdata_q <= rx_idl_q;
      if (ofs == `CMB_OFS_LENGTH)     rdata_q <= rx_len_q;
      if (ofs == `CMB_OFS_STAMP_HIGH) rdata_q <= rx_stamp_q[15:8];
      if (ofs == `CMB_OFS_STAMP_LOW)  rdata_q <= rx_stamp_q[7:0];
      if (is_data)                    rdata_q <= rx_data_q[dix];
    end else if (tx_win && sel_any) begin
      rdata_q <= 8'h00;
      if (ofs == `CMB_OFS_ID_HIGH)    rdata_q <= tx_idh_q[sel_idx];
      if (ofs == `CMB_OFS_ID_LOW)     rdata_q <= tx_idl_q[sel_idx];
      if (ofs == `CMB_OFS_LENGTH)     rdata_q <= tx_len_q[sel_idx];
      if (is_data)                    rdata_q <= tx_data_q[sel_idx][dix];
      if (sel_empty) begin
        if (ofs == `CMB_OFS_PRIORITY)   rdata_q <= tx_priority_field_q[sel_idx];
        if (ofs == `CMB_OFS_STAMP_HIGH) rdata_q <= tx_stamp_q[sel_idx][15:8];
        if (ofs == `CMB_OFS_STAMP_LOW)  rdata_q <= tx_stamp_q[sel_idx][7:0];
      end
    end else begin
      unique case (reg_addr)
        `CMB_ADDR_CTRL:       rdata_q <= ctrl_q;
        `CMB_ADDR_TX_FLAGS:   rdata_q <= 8'(empty_q);
        `CMB_ADDR_TX_SELECT:  rdata_q <= 8'(sel_q);
        `CMB_ADDR_IRQ_STATUS: rdata_q <= irq_stat_q;
        `CMB_ADDR_IRQ_MASK:   rdata_q <= irq_mask_q;
        default:              rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

endmodule : cmb_msg_buffers

// [tb/cmb_msg_buffers_asserts.sv]
// Concurrent checks on the transmit link outputs of the message buffers
`timescale 1ns/1ns
module cmb_msg_buffers_asserts (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       bit_tick,
  input wire logic       sof_request,
  input wire logic       tx_done,
  input wire logic       tx_sel_valid,
  input wire logic       tx_ide,
  input wire logic       tx_rtr,
  input wire logic [3:0] tx_dlc,
  input wire logic [3:0] tx_byte_count,
  input wire logic       tx_id_bit,
  input wire logic       tx_id_shifting
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] ticks_q;
  // Identifier bits shifted so far; a counter is cheaper than a long repetition
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ticks_q <= 4'h0;
    else if (!tx_id_shifting) ticks_q <= 4'h0;
    else if (bit_tick) ticks_q <= ticks_q + 4'h1;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_count_rule: assert property (tx_sel_valid |->
    tx_byte_count == (tx_rtr ? 4'h0 : (tx_dlc > 4'h8 ? 4'h8 : tx_dlc))) else $error("payload count wrong");
  chk_id_length: assert property ((tx_id_shifting && bit_tick && ticks_q == 4'ha) |=> !tx_id_shifting)
    else $error("identifier longer than eleven bits");
  chk_id_midway: assert property ((tx_id_shifting && bit_tick && ticks_q < 4'ha) |=> tx_id_shifting)
    else $error("identifier shorter than eleven bits");
  chk_id_steady: assert property ((tx_id_shifting && !bit_tick) |=> $stable(tx_id_bit))
    else $error("identifier bit moved without a tick");
  chk_sof_start: assert property ((sof_request && !tx_id_shifting) ##1 tx_sel_valid |-> tx_id_shifting)
    else $error("winner did not start shifting");
  chk_done_drop: assert property ((tx_done && tx_sel_valid && !sof_request) |=> !tx_sel_valid)
    else $error("selection kept after done");
  chk_fields_held: assert property (!sof_request |=> $stable({tx_ide, tx_rtr, tx_dlc}))
    else $error("frame fields changed outside arbitration");
  chk_idle_quiet: assert property (!tx_sel_valid |-> !tx_id_shifting)
    else $error("shifting with no winner");
  cover property (sof_request ##1 tx_sel_valid);
  cover property (tx_done && tx_sel_valid && tx_rtr);
  cover property (tx_sel_valid && tx_dlc > 4'h8);
endmodule : cmb_msg_buffers_asserts

bind cmb_msg_buffers cmb_msg_buffers_asserts chk_u (.*);

// [tb/cmb_can_node.sv]
// Protocol engine stand-in that frames transmit traffic from the buffers
`timescale 1ns/1ns
module cmb_can_node (
  input  wire logic       clk,
  input  wire logic       tx_sel_valid,
  input  wire logic       tx_id_bit,
  input  wire logic [3:0] tx_byte_count,
  input  wire logic [7:0] tx_byte_data,
  output logic            sof_request,
  output logic            bit_tick,
  output logic            tx_done,
  output logic [2:0]      tx_byte_idx
);
  logic [10:0] got_id;
  logic [7:0]  got_bytes[$];
  logic        got_valid;
  // Bit clock stands still between frames
  initial begin
    sof_request = 1'b0;
    bit_tick = 1'b0;
    tx_done = 1'b0;
    tx_byte_idx = 3'h0;
  end
  // ----------------------------------------
  // One arbitration round; gap slows the bit clock
  // ----------------------------------------
  task automatic frame(input int gap);
    got_bytes.delete();
    @(posedge clk);
    sof_request <= 1'b1;
    @(posedge clk);
    sof_request <= 1'b0;
    #1 got_valid = tx_sel_valid;
    if (got_valid) begin
      for (int i = 0; i < 11; i++) begin
        got_id = {got_id[9:0], tx_id_bit};
        bit_tick <= 1'b1;
        @(posedge clk);
        bit_tick <= 1'b0;
        repeat (gap) @(posedge clk);
        #1;
      end
      for (int j = 0; j < 8; j++) begin
        if (j < tx_byte_count) begin
          tx_byte_idx <= j[2:0];
          @(posedge clk);
          #1 got_bytes.push_back(tx_byte_data);
        end
      end
      tx_done <= 1'b1;
      @(posedge clk);
      tx_done <= 1'b0;
      tx_byte_idx <= ~tx_byte_idx;
    end
  endtask : frame
endmodule : cmb_can_node

// [tb/cmb_msg_buffers_test.sv]
// Self-checking bench for the CAN message buffers
`timescale 1ns/1ns
module cmb_msg_buffers_test;
  logic        clk, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, init_f = 1'b1;
  logic        rx_valid = 1'b0, rx_rtr = 1'b0, rx_ide = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, m_priority_field[3], m_dat[3][8], rx_mem[8];
  logic [10:0] rx_id = 11'h000, m_id[3];
  logic [3:0]  rx_dlc = 4'h0, m_dlc[3], tx_dlc, tx_byte_count;
  logic [63:0] rx_data = 64'h0;
  logic [31:0] rs = 32'h0fc8, x;
  logic [15:0] tmr = 16'h0, tstamp, rstamp;
  logic [15:0] m_stamp[3] = '{16'h0, 16'h0, 16'h0};
  logic [2:0]  pend, tx_byte_idx;
  logic [1:0]  tx_sel_index;
  logic [7:0]  reg_rdata, tx_byte_data;
  logic        m_rtr[3], m_ide[3], irq, sof_request, bit_tick, tx_done, tx_sel_valid;
  logic        tx_ide, tx_rtr, tx_id_bit, tx_id_shifting, init_mode;
  int          err_count = 0, num_checks = 0, cyc = 0, w, n;
  cmb_msg_buffers dut_u (.*);
  cmb_can_node node_u (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Reference timer and stamps; init mode is tracked from the bus writes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reg_wr && reg_addr == 8'h40) init_f <= reg_wdata[0];
    tmr <= init_f ? 16'h0 : tmr + {15'h0, bit_tick};
    if (tx_done) tstamp <= tmr;
    if (rx_valid) rstamp <= tmr;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({8'h0, reg_rdata}, {8'h0, e});
  endtask : rdc
  // Received frame: only counted bytes overwrite the window
  task automatic rx_frame(input logic rtr, input logic [3:0] dlc);
    logic [63:0] d;
    x = rnd();
    d = {rnd(), rnd()};
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_id <= x[10:0];
    rx_rtr <= rtr;
    rx_ide <= x[11];
    rx_dlc <= dlc;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    n = rtr ? 0 : (dlc > 4'h8 ? 8 : int'(dlc));
    for (int j = 0; j < n; j++) rx_mem[j] = d[8*j +: 8];
    rdc(8'h20, x[10:3]);
    rdc(8'h21, {x[2:0], rtr, x[11], 3'h0});
    for (int j = 0; j < 8; j++) rdc(8'h24 + j[7:0], rx_mem[j]);
    rdc(8'h2c, {4'h0, dlc});
    rdc(8'h43, 8'h08);
    rdc(8'h2e, rstamp[15:8]);
    rdc(8'h2f, rstamp[7:0]);
  endtask : rx_frame
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rdc(8'h41, 8'h07);
    rdc(8'h40, 8'h01);
    chk(init_mode, 1);
    rdc(8'h3d, 8'h00);
    rdc(8'h55, 8'h00);
    wr(8'h40, 8'h02);
    #1 chk(init_mode, 0);
    $display("test reset done");
    for (int r = 0; r < 2; r++) begin
      wr(8'h44, r ? 8'h00 : 8'h0f);
      for (int b = 0; b < 3; b++) begin
        x = rnd();
        m_id[b] = x[10:0];
        m_ide[b] = x[11];
        m_dlc[b] = x[15:12];
        m_priority_field[b] = {6'h0, x[17:16]};
        m_rtr[b] = (b == r);
        wr(8'h42, 8'h01 << b);
        if (r == 0) rdc(8'h3d, 8'h00);
        wr(8'h30, m_id[b][10:3]);
        wr(8'h31, {m_id[b][2:0], m_rtr[b], m_ide[b], 3'h0});
        for (int j = 0; j < 8; j++) begin
          x = rnd();
          m_dat[b][j] = x[7:0];
          wr(8'h34 + j[7:0], x[7:0]);
        end
        wr(8'h3c, {4'h0, m_dlc[b]});
        wr(8'h3d, m_priority_field[b]);
        rdc(8'h3d, m_priority_field[b]);
        wr(8'h3e, 8'hff);
        rdc(8'h3e, m_stamp[b][15:8]);
        wr(8'h41, 8'h01 << b);
        rdc(8'h3d, 8'h00);
        wr(8'h3d, ~m_priority_field[b]);
        rdc(8'h3e, 8'h00);
      end
      pend = 3'h7;
      for (int f = 0; f < 3; f++) begin
        w = -1;
        for (int b = 0; b < 3; b++) if (pend[b] && (w < 0 || m_priority_field[b] < m_priority_field[w])) w = b;
        node_u.frame(f);
        chk(tx_sel_index, w[1:0]);
        chk(node_u.got_id, m_id[w]);
        chk({tx_rtr, tx_ide, tx_dlc}, {m_rtr[w], m_ide[w], m_dlc[w]});
        n = m_rtr[w] ? 0 : (m_dlc[w] > 4'h8 ? 8 : int'(m_dlc[w]));
        chk(node_u.got_bytes.size(), n);
        foreach (node_u.got_bytes[j]) chk(node_u.got_bytes[j], m_dat[w][j]);
        #1 chk(tx_sel_valid, 0);
        chk(irq, r == 0);
        pend[w] = 1'b0;
        rdc(8'h43, 8'h01 << w);
        chk(irq, 0);
        rdc(8'h41, {5'h0, ~pend});
        wr(8'h42, 8'h01 << w);
        rdc(8'h3e, tstamp[15:8]);
        rdc(8'h3f, tstamp[7:0]);
        rdc(8'h3d, m_priority_field[w]);
        m_stamp[w] = tstamp;
      end
      $display("test transmit round done");
    end
    node_u.frame(0);
    chk(node_u.got_valid, 0);
    rx_frame(1'b0, 4'h8);
    rx_frame(1'b1, 4'h5);
    rx_frame(1'b0, 4'h3);
    wr(8'h40, 8'h03);
    #1 chk(init_mode, 1);
    wr(8'h40, 8'h02);
    rx_frame(1'b0, 4'hc);
    $display("test receive done");
    final_report();
  end
endmodule : cmb_msg_buffers_test
